// *** hdl/pcs_pkg.sv ***
// Constants for the output, slip prevention and status register bank.
// Assumes a word-addressed register port with 24-bit data words.
package pcs_pkg;
  localparam int ADDR_W = 6;
  localparam int DATA_W = 24;
  localparam logic [5:0] AUX_OUTPUT_CONTROL_ADDR = 6'h1b;
  localparam logic [5:0] SLIP_PREVENTION_CONTROL_ADDR = 6'h1c;
  localparam logic [5:0] RESERVED_BLOCK_A_ADDR = 6'h1d;
  localparam logic [5:0] TEMP_SENSOR_ENABLE_ADDR = 6'h1e;
  localparam logic [5:0] LOCK_SWEEP_STATUS_ADDR = 6'h1f;
  localparam logic [5:0] RESERVED_BLOCK_B_ADDR = 6'h20;
  localparam logic [5:0] TEMPERATURE_READOUT_ADDR = 6'h21;
  localparam logic [5:0] RESERVED_BLOCK_C_ADDR = 6'h22;
  // Aux output control fields
  localparam int SRC_SEL_LSB = 0;
  localparam int STATIC_VAL_LSB = 4;
  localparam int DRIVE_EN_BIT = 7;
  localparam int PIN_DIS_LSB = 8;
  localparam logic [3:0] SRC_SEL_STATIC = 4'h0;
  localparam logic [3:0] SRC_SEL_RST = 4'h0;
  localparam logic [2:0] STATIC_VAL_RST = 3'h0;
  localparam logic DRIVE_EN_RST = 1'b0;
  localparam logic [2:0] PIN_DIS_RST = 3'h0;
  // Slip prevention fields
  localparam int STEP_LSB = 0;
  localparam int RST_FORCE_BIT = 4;
  localparam int RST_CTRL_BIT = 5;
  localparam logic [3:0] STEP_RST = 4'h0;
  localparam logic RST_FORCE_RST = 1'b0;
  localparam logic RST_CTRL_RST = 1'b1;
  // Temperature sensor enable
  localparam int TSENS_EN_BIT = 0;
  localparam logic TSENS_EN_RST = 1'b0;
  // Status fields
  localparam int LOCK_BIT = 0;
  localparam int OVF_LSB = 1;
  localparam int SWEEP_BIT = 5;
  localparam int TEMP_LSB = 0;
  localparam logic [6:0] TEMP_MAX_CODE = 7'h07;
  localparam logic [6:0] TEMP_CODE_RST = 7'h1f;
  // Temperature conversion in tenths of a degree
  localparam int TEMP_OFFSET_TENTHS = 400;
  localparam int TEMP_STEP_TENTHS = 175;
  localparam int TEMP_LOW_TENTHS = -225;
  localparam int TEMP_HIGH_TENTHS = 825;
  localparam logic [23:0] RESERVED_A_VAL = 24'h000000;
  localparam logic [23:0] RESERVED_B_VAL = 24'h000020;
  localparam logic [23:0] RESERVED_C_VAL = 24'h000000;
endpackage : pcs_pkg

// *** hdl/pcs_regs.sv ***
// Control and status register bank for aux pin drive, slip prevention and status.
// Assumes a synchronous word-wide register port from the serial port decoder.
`timescale 1ns/10ps

module pcs_regs #(
  parameter int TEMP_W = 12
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [pcs_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [pcs_pkg::DATA_W-1:0] reg_wdata,
  output logic [pcs_pkg::DATA_W-1:0] reg_rdata,
  output logic reg_rvalid,
  input wire logic [2:0] aux_src_data,
  output logic [2:0] aux_pin_o,
  output logic [2:0] aux_pin_oe,
  input wire logic slip_enable_ext,
  input wire logic auto_reset_n,
  output logic slip_active,
  output logic slip_polarity,
  output logic [2:0] slip_magnitude,
  output logic detector_reset_n,
  output logic charge_pump_tristate,
  output logic temp_sensor_en,
  input wire logic lock_flag,
  input wire logic [2:0] modulator_overflow_flags,
  input wire logic sweep_active_flag,
  input wire logic signed [TEMP_W-1:0] temp_tenths
);

  // ==========================================================
  // Write decode
  logic aux_wr_hit;
  logic slip_wr_hit;
  logic tsens_wr_hit;

  // Writes to read-only, reserved and unmapped words hit nothing
  always_comb begin
    aux_wr_hit = reg_wr && (reg_addr == pcs_pkg::AUX_OUTPUT_CONTROL_ADDR);
    slip_wr_hit = reg_wr && (reg_addr == pcs_pkg::SLIP_PREVENTION_CONTROL_ADDR);
    tsens_wr_hit = reg_wr && (reg_addr == pcs_pkg::TEMP_SENSOR_ENABLE_ADDR);
  end

  // ==========================================================
  // Aux output control register
  logic [3:0] src_sel_r;
  logic [2:0] static_val_r;
  logic drive_en_r;
  logic [2:0] pin_dis_r;

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      src_sel_r <= pcs_pkg::SRC_SEL_RST;
    end else if (aux_wr_hit) begin
      src_sel_r <= reg_wdata[pcs_pkg::SRC_SEL_LSB +: 4];
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      static_val_r <= pcs_pkg::STATIC_VAL_RST;
    end else if (aux_wr_hit) begin
      static_val_r <= reg_wdata[pcs_pkg::STATIC_VAL_LSB +: 3];
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      drive_en_r <= pcs_pkg::DRIVE_EN_RST;
    end else if (aux_wr_hit) begin
      drive_en_r <= reg_wdata[pcs_pkg::DRIVE_EN_BIT];
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      pin_dis_r <= pcs_pkg::PIN_DIS_RST;
    end else if (aux_wr_hit) begin
      pin_dis_r <= reg_wdata[pcs_pkg::PIN_DIS_LSB +: 3];
    end
  end

  // ==========================================================
  // Slip prevention control register
  logic [3:0] slip_correction_step_r;
  logic rst_force_r;
  logic rst_ctrl_r;

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      slip_correction_step_r <= pcs_pkg::STEP_RST;
    end else if (slip_wr_hit) begin
      slip_correction_step_r <= reg_wdata[pcs_pkg::STEP_LSB +: 4];
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      rst_force_r <= pcs_pkg::RST_FORCE_RST;
    end else if (slip_wr_hit) begin
      rst_force_r <= reg_wdata[pcs_pkg::RST_FORCE_BIT];
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      rst_ctrl_r <= pcs_pkg::RST_CTRL_RST;
    end else if (slip_wr_hit) begin
      rst_ctrl_r <= reg_wdata[pcs_pkg::RST_CTRL_BIT];
    end
  end

  // ==========================================================
  // Temperature sensor enable register
  logic tsens_en_r;

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      tsens_en_r <= pcs_pkg::TSENS_EN_RST;
    end else if (tsens_wr_hit) begin
      tsens_en_r <= reg_wdata[pcs_pkg::TSENS_EN_BIT];
    end
  end

  assign temp_sensor_en = tsens_en_r;

  // ==========================================================
  // Aux pin drive, one slice per pin
  logic [2:0] aux_sel_val;
  logic [2:0] aux_pin_vec;
  logic [2:0] aux_oe_vec;

  always_comb begin
    if (src_sel_r == pcs_pkg::SRC_SEL_STATIC) begin
      aux_sel_val = static_val_r;
    end else begin
      aux_sel_val = aux_src_data;
    end
  end

  // Bit zero of each field belongs to pin zero
  for (genvar pin = 0; pin < 3; pin++) begin : g_aux_pin
    logic pin_val_r;
    logic pin_oe_r;

    always_ff @(posedge clk) begin
      if (!reset_n) begin
        pin_val_r <= 1'b0;
      end else begin
        pin_val_r <= aux_sel_val[pin];
      end
    end

    // Global enable gates the per-pin mask
    always_ff @(posedge clk) begin
      if (!reset_n) begin
        pin_oe_r <= 1'b0;
      end else begin
        pin_oe_r <= drive_en_r && !pin_dis_r[pin];
      end
    end

    assign aux_pin_vec[pin] = pin_val_r;
    assign aux_oe_vec[pin] = pin_oe_r;
  end

  assign aux_pin_o = aux_pin_vec;
  assign aux_pin_oe = aux_oe_vec;

  // ==========================================================
  // Slip prevention controls
  logic step_nonzero;
  logic det_rst_n_r;
  logic slip_active_r;

  assign step_nonzero = (slip_correction_step_r != 4'h0);

  // Software takes over the detector reset while the override is set
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      det_rst_n_r <= 1'b1;
    end else if (rst_force_r) begin
      det_rst_n_r <= rst_ctrl_r;
    end else begin
      det_rst_n_r <= auto_reset_n;
    end
  end

  // Correction needs a nonzero step, the reset control and the outside enable
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      slip_active_r <= 1'b0;
    end else begin
      slip_active_r <= step_nonzero && rst_ctrl_r && slip_enable_ext;
    end
  end

  assign detector_reset_n = det_rst_n_r;
  assign charge_pump_tristate = ~det_rst_n_r;
  assign slip_active = slip_active_r;
  assign slip_polarity = slip_correction_step_r[0];
  assign slip_magnitude = slip_correction_step_r[3:1];

  // ==========================================================
  // Temperature code from tenths of a degree: (t + 400) / 175
  logic signed [TEMP_W+1:0] temp_wide;
  logic signed [TEMP_W+1:0] temp_shift;
  logic [TEMP_W+1:0] temp_quot;
  logic temp_at_low;
  logic temp_at_high;
  logic [6:0] temp_code_nxt;
  logic [6:0] temp_code_r;

  always_comb begin
    temp_wide = (TEMP_W+2)'(temp_tenths);
    temp_shift = temp_wide + (TEMP_W+2)'(pcs_pkg::TEMP_OFFSET_TENTHS);
    temp_quot = (TEMP_W+2)'(temp_shift / (TEMP_W+2)'(pcs_pkg::TEMP_STEP_TENTHS));
  end

  // Clamp first; the divide only counts inside the range
  always_comb begin
    temp_at_low = (temp_wide <= (TEMP_W+2)'(pcs_pkg::TEMP_LOW_TENTHS));
    temp_at_high = (temp_wide >= (TEMP_W+2)'(pcs_pkg::TEMP_HIGH_TENTHS));
  end

  always_comb begin
    if (temp_at_low) begin
      temp_code_nxt = 7'h00;
    end else if (temp_at_high) begin
      temp_code_nxt = pcs_pkg::TEMP_MAX_CODE;
    end else begin
      temp_code_nxt = temp_quot[6:0];
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      temp_code_r <= pcs_pkg::TEMP_CODE_RST;
    end else begin
      temp_code_r <= temp_code_nxt;
    end
  end

  // ==========================================================
  // Read words; fields sit in the low bits, upper bits read zero
  logic [pcs_pkg::DATA_W-1:0] aux_word;
  logic [pcs_pkg::DATA_W-1:0] slip_word;
  logic [pcs_pkg::DATA_W-1:0] tsens_word;
  logic [pcs_pkg::DATA_W-1:0] status_word;
  logic [pcs_pkg::DATA_W-1:0] temp_word;

  always_comb begin
    aux_word = '0;
    aux_word[pcs_pkg::SRC_SEL_LSB +: 4] = src_sel_r;
    aux_word[pcs_pkg::STATIC_VAL_LSB +: 3] = static_val_r;
    aux_word[pcs_pkg::DRIVE_EN_BIT] = drive_en_r;
    aux_word[pcs_pkg::PIN_DIS_LSB +: 3] = pin_dis_r;
  end

  always_comb begin
    slip_word = '0;
    slip_word[pcs_pkg::STEP_LSB +: 4] = slip_correction_step_r;
    slip_word[pcs_pkg::RST_FORCE_BIT] = rst_force_r;
    slip_word[pcs_pkg::RST_CTRL_BIT] = rst_ctrl_r;
  end

  always_comb begin
    tsens_word = '0;
    tsens_word[pcs_pkg::TSENS_EN_BIT] = tsens_en_r;
  end

  // Status flags are read live
  always_comb begin
    status_word = '0;
    status_word[pcs_pkg::LOCK_BIT] = lock_flag;
    status_word[pcs_pkg::OVF_LSB +: 3] = modulator_overflow_flags;
    status_word[pcs_pkg::SWEEP_BIT] = sweep_active_flag;
  end

  always_comb begin
    temp_word = '0;
    temp_word[pcs_pkg::TEMP_LSB +: 7] = temp_code_r;
  end

  // ==========================================================
  // Read path
  logic [pcs_pkg::DATA_W-1:0] rdata_nxt;
  logic [pcs_pkg::DATA_W-1:0] rdata_r;
  logic rvalid_r;

  always_comb begin
    case (reg_addr)
      pcs_pkg::AUX_OUTPUT_CONTROL_ADDR: rdata_nxt = aux_word;
      pcs_pkg::SLIP_PREVENTION_CONTROL_ADDR: rdata_nxt = slip_word;
      pcs_pkg::RESERVED_BLOCK_A_ADDR: rdata_nxt = pcs_pkg::RESERVED_A_VAL;
      pcs_pkg::TEMP_SENSOR_ENABLE_ADDR: rdata_nxt = tsens_word;
      pcs_pkg::LOCK_SWEEP_STATUS_ADDR: rdata_nxt = status_word;
      pcs_pkg::RESERVED_BLOCK_B_ADDR: rdata_nxt = pcs_pkg::RESERVED_B_VAL;
      pcs_pkg::TEMPERATURE_READOUT_ADDR: rdata_nxt = temp_word;
      pcs_pkg::RESERVED_BLOCK_C_ADDR: rdata_nxt = pcs_pkg::RESERVED_C_VAL;
      default: rdata_nxt = '0;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      rvalid_r <= 1'b0;
    end else begin
      rvalid_r <= reg_rd;
    end
  end

  // Read data holds until the next read
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      rdata_r <= '0;
    end else if (reg_rd) begin
      rdata_r <= rdata_nxt;
    end
  end

  assign reg_rdata = rdata_r;
  assign reg_rvalid = rvalid_r;

endmodule : pcs_regs

// *** tb/pcs_regs_checker.sv ***
// Port assertions for the aux pin, slip prevention and status register bank.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/10ps
module pcs_regs_checker (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [pcs_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [pcs_pkg::DATA_W-1:0] reg_wdata,
  input wire logic [pcs_pkg::DATA_W-1:0] reg_rdata,
  input wire logic [2:0] aux_pin_o,
  input wire logic [2:0] aux_pin_oe,
  input wire logic slip_enable_ext,
  input wire logic slip_active,
  input wire logic slip_polarity,
  input wire logic [2:0] slip_magnitude,
  input wire logic detector_reset_n,
  input wire logic charge_pump_tristate,
  input wire logic lock_flag,
  input wire logic [2:0] modulator_overflow_flags,
  input wire logic sweep_active_flag
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  logic [23:0] wd_q;
  logic [23:0] wd_qq;
  always_ff @(posedge clk) begin
    wd_q <= reg_wdata;
    wd_qq <= wd_q;
  end
  // Aux write followed by a quiet cycle
  sequence aux_wr;
    reg_wr && reg_addr == pcs_pkg::AUX_OUTPUT_CONTROL_ADDR ##1 !reg_wr;
  endsequence
  a_static_pins: assert property (aux_wr |-> ##1 (wd_qq[3:0] != 4'h0 || aux_pin_o == wd_qq[6:4]))
    else $error("static value not on pins");
  a_oe_off: assert property (aux_wr |-> ##1 (wd_qq[7] || aux_pin_oe == 3'h0))
    else $error("pins driven while disabled");
  a_oe_mask: assert property (aux_wr |-> ##1 (!wd_qq[7] || aux_pin_oe == ~wd_qq[10:8]))
    else $error("pin enable mask wrong");
  a_status_read: assert property (reg_rd && reg_addr == pcs_pkg::LOCK_SWEEP_STATUS_ADDR |=>
    reg_rdata == {18'h0, $past(sweep_active_flag), 1'b0, $past(modulator_overflow_flags),
    $past(lock_flag)}) else $error("status word wrong");
  a_pump_tristate: assert property (charge_pump_tristate == !detector_reset_n)
    else $error("pump state not tied to detector reset");
  a_step_zero_off: assert property ((slip_magnitude == 3'h0 && !slip_polarity) [*2] |-> !slip_active)
    else $error("slip active with zero step");
  a_step_fields: assert property (reg_wr && reg_addr == pcs_pkg::SLIP_PREVENTION_CONTROL_ADDR |=>
    {slip_magnitude, slip_polarity} == wd_q[3:0]) else $error("step fields wrong");
  a_ext_enable: assert property (!slip_enable_ext [*2] |-> !slip_active)
    else $error("slip active without outside enable");
endmodule : pcs_regs_checker

// *** tb/pcs_regs_tb.sv ***
// Self-checking bench for the register bank.
// Assumes the bench drives every port itself.
`timescale 1ns/10ps
module pcs_regs_tb;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [5:0] reg_addr = 6'h00;
  logic [23:0] reg_wdata = 24'h0, reg_rdata;
  logic reg_rvalid, slip_active, slip_polarity, detector_reset_n, charge_pump_tristate, tsen;
  logic [2:0] aux_src_data = 3'h0, aux_pin_o, aux_pin_oe, slip_magnitude;
  logic [2:0] modulator_overflow_flags = 3'h0;
  logic slip_enable_ext = 1'b0, auto_reset_n = 1'b1, lock_flag = 1'b0, sweep_active_flag = 1'b0;
  logic signed [11:0] temp_tenths = 12'sh000;
  int bad_count = 0;
  int checks_done = 0;
  always #4 clk = ~clk;
  pcs_regs #(.TEMP_W(12)) dut (.clk(clk), .reset_n(reset_n), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .aux_src_data(aux_src_data), .aux_pin_o(aux_pin_o), .aux_pin_oe(aux_pin_oe),
    .slip_enable_ext(slip_enable_ext), .auto_reset_n(auto_reset_n), .slip_active(slip_active),
    .slip_polarity(slip_polarity), .slip_magnitude(slip_magnitude),
    .detector_reset_n(detector_reset_n), .charge_pump_tristate(charge_pump_tristate),
    .temp_sensor_en(tsen), .lock_flag(lock_flag), .modulator_overflow_flags(modulator_overflow_flags),
    .sweep_active_flag(sweep_active_flag), .temp_tenths(temp_tenths));
  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : complete_run
  task automatic chk(input string nm, input logic [23:0] exp, input logic [23:0] got);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick
  task automatic wr(input logic [5:0] a, input logic [23:0] d);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    tick(1);
    reg_wr = 1'b0;
    tick(1);
  endtask : wr
  task automatic rd(input logic [5:0] a, input logic [23:0] exp);
    reg_rd = 1'b1;
    reg_addr = a;
    tick(1);
    reg_rd = 1'b0;
    chk("rvalid", 24'h1, {23'h0, reg_rvalid});
    chk("rdata", exp, reg_rdata);
    tick(1);
  endtask : rd
  task automatic t_reset();
    rd(pcs_pkg::SLIP_PREVENTION_CONTROL_ADDR, 24'h000020);
    rd(pcs_pkg::AUX_OUTPUT_CONTROL_ADDR, 24'h0);
    rd(pcs_pkg::RESERVED_BLOCK_B_ADDR, 24'h000020);
    rd(6'h3f, 24'h0);
    chk("oe", 24'h0, {21'h0, aux_pin_oe});
    chk("tsens", 24'h0, {23'h0, tsen});
    wr(pcs_pkg::TEMP_SENSOR_ENABLE_ADDR, 24'h000001);
    chk("tsens on", 24'h1, {23'h0, tsen});
    rd(pcs_pkg::TEMP_SENSOR_ENABLE_ADDR, 24'h000001);
  endtask : t_reset
  task automatic t_aux();
    wr(pcs_pkg::AUX_OUTPUT_CONTROL_ADDR, 24'h000750);
    chk("pins", 24'h5, {21'h0, aux_pin_o});
    chk("oe off", 24'h0, {21'h0, aux_pin_oe});
    for (int i = 0; i < 3; i++) begin
      wr(pcs_pkg::AUX_OUTPUT_CONTROL_ADDR, {13'h0, 3'(1 << i), 8'hd0});
      chk("oe mask", {21'h0, ~3'(1 << i)}, {21'h0, aux_pin_oe});
    end
    aux_src_data = 3'h6;
    wr(pcs_pkg::AUX_OUTPUT_CONTROL_ADDR, 24'h000081);
    chk("src pins", 24'h6, {21'h0, aux_pin_o});
    chk("oe all", 24'h7, {21'h0, aux_pin_oe});
  endtask : t_aux
  task automatic t_slip();
    slip_enable_ext = 1'b1;
    wr(pcs_pkg::SLIP_PREVENTION_CONTROL_ADDR, 24'h00002b);
    chk("slip", 24'hd, {20'h0, slip_active, slip_magnitude});
    chk("polarity", 24'h1, {23'h0, slip_polarity});
    wr(pcs_pkg::SLIP_PREVENTION_CONTROL_ADDR, 24'h00000b);
    chk("slip gated", 24'h0, {23'h0, slip_active});
    slip_enable_ext = 1'b0;
    wr(pcs_pkg::SLIP_PREVENTION_CONTROL_ADDR, 24'h00002b);
    chk("slip no ext", 24'h0, {23'h0, slip_active});
    slip_enable_ext = 1'b1;
    wr(pcs_pkg::SLIP_PREVENTION_CONTROL_ADDR, 24'h000020);
    chk("slip off", 24'h0, {23'h0, slip_active});
    wr(pcs_pkg::SLIP_PREVENTION_CONTROL_ADDR, 24'h000010);
    chk("det sw", 24'h2, {22'h0, charge_pump_tristate, detector_reset_n});
    auto_reset_n = 1'b0;
    wr(pcs_pkg::SLIP_PREVENTION_CONTROL_ADDR, 24'h000000);
    chk("det auto", 24'h0, {23'h0, detector_reset_n});
    auto_reset_n = 1'b1;
  endtask : t_slip
  task automatic t_status();
    lock_flag = 1'b1;
    modulator_overflow_flags = 3'h5;
    sweep_active_flag = 1'b1;
    wr(pcs_pkg::LOCK_SWEEP_STATUS_ADDR, 24'hffffff);
    rd(pcs_pkg::LOCK_SWEEP_STATUS_ADDR, 24'h00002b);
  endtask : t_status
  task automatic t_temp();
    logic signed [11:0] tv [7] = '{12'sh339, 12'sh338, 12'sh000, 12'shed4, 12'sh3e8,
      12'shf1f, 12'shf20};
    logic [23:0] ev [7] = '{24'h7, 24'h6, 24'h2, 24'h0, 24'h7, 24'h0, 24'h1};
    for (int i = 0; i < 7; i++) begin
      temp_tenths = tv[i];
      tick(3);
      rd(pcs_pkg::TEMPERATURE_READOUT_ADDR, ev[i]);
    end
  endtask : t_temp
  initial begin
    tick(5);
    reset_n = 1'b1;
    tick(1);
    t_reset();
    t_aux();
    t_slip();
    t_status();
    t_temp();
    complete_run();
  end
  initial begin
    #20000;
    bad_count++;
    complete_run();
  end
endmodule : pcs_regs_tb
bind pcs_regs pcs_regs_checker u_chk (.clk(clk), .reset_n(reset_n), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
  .aux_pin_o(aux_pin_o), .aux_pin_oe(aux_pin_oe), .slip_enable_ext(slip_enable_ext),
  .slip_active(slip_active), .slip_polarity(slip_polarity), .slip_magnitude(slip_magnitude),
  .detector_reset_n(detector_reset_n), .charge_pump_tristate(charge_pump_tristate),
  .lock_flag(lock_flag), .modulator_overflow_flags(modulator_overflow_flags),
  .sweep_active_flag(sweep_active_flag));
